// *** design/wpr_defs.vh ***
// constants for the wiper position register block
`ifndef WPR_DEFS_VH
`define WPR_DEFS_VH

// clock period of core_clk in ns
`define WPR_CLK_NS        4
// register addresses carried in the address byte
`define WPR_ADDR_WIPER    8'h00
`define WPR_ADDR_INIT     8'h01
// reset and preset values
`define WPR_WIPER_RST     7'h40
`define WPR_INIT_RST      7'h40
// slave identity, seven address bits (arbitrary value)
`define WPR_SLAVE_ID      7'h2a
// glitch suppression width in ns and in cycles, rounded up
`define WPR_FILT_NS       50
`define WPR_FILT_CYC      ((`WPR_FILT_NS + `WPR_CLK_NS - 1) / `WPR_CLK_NS)
// wiper response time in ns and in cycles, rounded down
`define WPR_RESP_NS       500
`define WPR_RESP_CYC      (`WPR_RESP_NS / `WPR_CLK_NS)
// power-up recall delay in ms and in cycles, rounded down
`define WPR_PWRUP_MS      3
`define WPR_PWRUP_CYC     (`WPR_PWRUP_MS * 1000000 / `WPR_CLK_NS)

`endif

// *** design/wpr_wiper_position_register.v ***
// two-wire slave holding the 7-bit wiper setting and its initial value
`timescale 1ns/1ns
`include "wpr_defs.vh"

// Function
// - one 7-bit volatile register picks wiper tap
// - zero is low end, ones high end
// - tap position rises monotonically with code
// - power-up presets register to midscale code
// - wiper and initial value are bus accessible
// - recall done, interface ready within 3 ms
// - bus pulses under 50 ns are ignored
// - address zero write loads on last fall
// - bad slave or register address gets no ack
// - wiper output follows write after 500 ns
// - every byte moves most significant bit first
module wpr_wiper_position_register #(
   parameter PWRUP_CYC = `WPR_PWRUP_CYC,
   parameter FILT_CYC  = `WPR_FILT_CYC,
   parameter RESP_CYC  = `WPR_RESP_CYC
) (
   input  wire         core_clk,
   input  wire         nrst,
   input  wire         scl_in,
   input  wire         sda_in,
   output reg          sda_out,
   output reg          sda_oe,
   output reg  [6:0]   wiper_code,
   output reg  [127:0] tap_sel,
   output reg          if_ready
);

   // fsm states
   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_RX   = 3'd1;
   localparam [2:0] ST_ACK  = 3'd2;
   localparam [2:0] ST_TX   = 3'd3;
   localparam [2:0] ST_MACK = 3'd4;
   // kinds of received byte
   localparam [1:0] KD_ID   = 2'd0;
   localparam [1:0] KD_REG  = 2'd1;
   localparam [1:0] KD_DATA = 2'd2;

   ////////////////////////////////////////////////////////////////////
   // input synchronisers and glitch filters, bit 0 scl, bit 1 sda
   wire [1:0] pin_raw = {sda_in, scl_in};   // raw pin levels
   reg  [1:0] sync1_q;                      // first sync stage
   reg  [1:0] sync2_q;                      // second sync stage
   wire [1:0] filt_q;                       // filtered levels, one flop per pin
   reg  [1:0] filt_prev_q;                  // filtered levels one cycle back

   // first stage feeds only the second
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1_q <= 2'b11;
         sync2_q <= 2'b11;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
         reg [7:0] cnt_q;   // cycles the new level has held
         reg       lvl_q;   // accepted level of this pin
         assign filt_q[gi] = lvl_q;
         // level accepted only after it holds the whole filter width
         always @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               cnt_q <= 8'h00;
               lvl_q <= 1'b1;
            end else if (sync2_q[gi] == lvl_q) begin
               cnt_q <= 8'h00;   // short pulse forgotten
            end else if (cnt_q == FILT_CYC[7:0] - 8'h01) begin
               cnt_q <= 8'h00;
               lvl_q <= sync2_q[gi];
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   endgenerate

   // previous filtered levels for edge finding
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         filt_prev_q <= 2'b11;
      end else begin
         filt_prev_q <= filt_q;
      end
   end

   wire scl_rise = filt_q[0] & ~filt_prev_q[0];                     // clock rising
   wire scl_fall = ~filt_q[0] & filt_prev_q[0];                     // clock falling
   wire bus_start = filt_q[0] & filt_prev_q[0] & ~filt_q[1] & filt_prev_q[1];
   wire bus_stop  = filt_q[0] & filt_prev_q[0] & filt_q[1] & ~filt_prev_q[1];

   ////////////////////////////////////////////////////////////////////
   // power-up recall delay
   reg [19:0] pwr_cnt_q;   // cycles since power-on
   reg        recall_q;    // one-cycle pulse that recalls the initial value

   // count out the power-up delay, then open the interface
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pwr_cnt_q <= 20'h00000;
         if_ready  <= 1'b0;
         recall_q  <= 1'b0;
      end else begin
         recall_q <= 1'b0;
         if (!if_ready) begin
            if (pwr_cnt_q == PWRUP_CYC[19:0] - 20'h00001) begin
               if_ready <= 1'b1;
               recall_q <= 1'b1;
            end else begin
               pwr_cnt_q <= pwr_cnt_q + 20'h00001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // serial protocol engine and registers
   reg [2:0] st_q;        // protocol state
   reg [1:0] kind_q;      // kind of byte being received
   reg [3:0] bit_q;       // bit counter within byte
   reg [7:0] sh_q;        // shift register, msb first
   reg [7:0] addr_q;      // selected register address
   reg       rd_q;        // read requested by identity byte
   reg       mack_q;      // master acknowledged last read byte
   reg [6:0] init_q;      // initial value register
   reg       wr_pulse_q;  // wiper written, start response delay

   wire [7:0] rd_byte = {1'b0, (addr_q == `WPR_ADDR_INIT) ? init_q : wiper_code};
   wire       id_ok   = (sh_q[7:1] == `WPR_SLAVE_ID);
   wire       reg_ok  = (sh_q == `WPR_ADDR_WIPER) || (sh_q == `WPR_ADDR_INIT);

   // byte framing, acknowledge and register loads
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_q       <= ST_IDLE;
         kind_q     <= KD_ID;
         bit_q      <= 4'h0;
         sh_q       <= 8'h00;
         addr_q     <= 8'h00;
         rd_q       <= 1'b0;
         mack_q     <= 1'b0;
         sda_oe     <= 1'b0;
         sda_out    <= 1'b0;
         init_q     <= `WPR_INIT_RST;
         wiper_code <= `WPR_WIPER_RST;
         wr_pulse_q <= 1'b0;
      end else begin
         wr_pulse_q <= 1'b0;
         sda_out    <= 1'b0;
         if (recall_q) begin
            wiper_code <= init_q;   // recall
            wr_pulse_q <= 1'b1;
         end
         if (!if_ready || bus_stop) begin
            st_q   <= ST_IDLE;   // start ignored while powering up
            sda_oe <= 1'b0;
         end else if (bus_start) begin
            st_q   <= ST_RX;
            kind_q <= KD_ID;
            bit_q  <= 4'h0;
            sda_oe <= 1'b0;
         end else begin
            case (st_q)
               ST_RX: begin
                  if (scl_rise) begin
                     sh_q  <= {sh_q[6:0], filt_q[1]};   // msb first
                     bit_q <= bit_q + 4'h1;
                  end else if (scl_fall && bit_q == 4'h8) begin
                     bit_q <= 4'h0;
                     if (kind_q == KD_ID) begin
                        rd_q   <= sh_q[0];
                        st_q   <= id_ok ? ST_ACK : ST_IDLE;
                        sda_oe <= id_ok;
                     end else if (kind_q == KD_REG) begin
                        addr_q <= sh_q;
                        st_q   <= reg_ok ? ST_ACK : ST_IDLE;
                        sda_oe <= reg_ok;
                     end else begin
                        if (addr_q == `WPR_ADDR_WIPER) begin
                           wiper_code <= sh_q[6:0];
                           wr_pulse_q <= 1'b1;
                        end else begin
                           init_q <= sh_q[6:0];
                        end
                        st_q   <= ST_ACK;
                        sda_oe <= 1'b1;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (kind_q == KD_ID && rd_q) begin
                        sh_q   <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bit_q  <= 4'h0;
                        st_q   <= ST_TX;
                     end else if (kind_q == KD_DATA) begin
                        sda_oe <= 1'b0;
                        st_q   <= ST_IDLE;   // standby until next start
                     end else begin
                        sda_oe <= 1'b0;
                        kind_q <= kind_q + 2'd1;
                        st_q   <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (bit_q == 4'h7) begin
                        sda_oe <= 1'b0;   // release for master ack
                        st_q   <= ST_MACK;
                     end else begin
                        sh_q   <= {sh_q[6:0], 1'b0};
                        sda_oe <= ~sh_q[6];
                        bit_q  <= bit_q + 4'h1;
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     mack_q <= ~filt_q[1];
                  end else if (scl_fall) begin
                     if (mack_q) begin
                        sh_q   <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        bit_q  <= 4'h0;
                        st_q   <= ST_TX;
                     end else begin
                        st_q <= ST_IDLE;
                     end
                  end
               end
               default: begin
                  st_q   <= ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // wiper response delay and one-hot tap decode
   reg [7:0] resp_cnt_q;   // cycles counted since the wiper write
   reg       resp_busy_q;  // delay running
   wire [127:0] tap_dec;   // decoded tap selection

   generate
      for (gi = 0; gi < 128; gi = gi + 1) begin : g_tap
         // tap 0 at low end, tap 127 at high end
         assign tap_dec[gi] = ({25'h0000000, wiper_code} == gi);
      end
   endgenerate

   // taps follow the register after the response time
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         resp_cnt_q  <= 8'h00;
         resp_busy_q <= 1'b0;
         tap_sel     <= 128'h0;
      end else if (!if_ready && !recall_q) begin
         tap_sel <= tap_dec;   // preset midscale shown during power-up
      end else if (wr_pulse_q) begin
         resp_cnt_q  <= 8'h00;
         resp_busy_q <= 1'b1;
      end else if (resp_busy_q) begin
         if (resp_cnt_q == RESP_CYC[7:0] - 8'h02) begin
            resp_busy_q <= 1'b0;
            tap_sel     <= tap_dec;
         end else begin
            resp_cnt_q <= resp_cnt_q + 8'h01;
         end
      end
   end

endmodule

// *** sim/wpr_checker_props.sv ***
// checker for the wiper position register ports
`timescale 1ns/1ns
module wpr_checker #(
   parameter PWRUP_CYC = 200,
   parameter RESP_CYC  = 125
) (
   input wire         core_clk,
   input wire         nrst,
   input wire         scl_in,
   input wire         sda_oe,
   input wire [6:0]   wiper_code,
   input wire [127:0] tap_sel,
   input wire         if_ready
);
   localparam int RDY_MAX = PWRUP_CYC + 3; // recall bound with margin for the release edge
   localparam int TAP_LAG = RESP_CYC + 2;  // wiper settle bound with two cycles margin
   a_reset_state: assert property (@(posedge core_clk) !nrst |->
      wiper_code == 7'h40 && !sda_oe && !if_ready && tap_sel == 128'h0) else $error("bad reset state");
   a_tap_onehot: assert property (@(posedge core_clk) disable iff (!nrst)
      $past(nrst) |-> $onehot(tap_sel)) else $error("taps not one-hot");
   a_tap_follows: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(wiper_code) |-> ##TAP_LAG tap_sel == 128'h1 << wiper_code) else $error("taps off code");
   a_tap_waits: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(wiper_code) |=> $stable(tap_sel)) else $error("taps moved early");
   a_ready_bound: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(nrst) |-> ##[1:RDY_MAX] if_ready) else $error("not ready in time");
   a_quiet_early: assert property (@(posedge core_clk) disable iff (!nrst)
      !if_ready |-> !sda_oe) else $error("bus driven before ready");
   a_load_acks: assert property (@(posedge core_clk) disable iff (!nrst)
      $changed(wiper_code) && $past(nrst) |-> $rose(sda_oe) && !scl_in) else $error("load off the ack");
   a_ack_holds: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(sda_oe) |=> sda_oe [*8]) else $error("ack too short");
endmodule

bind wpr_wiper_position_register wpr_checker #(.PWRUP_CYC(PWRUP_CYC), .RESP_CYC(RESP_CYC)) u_chk (
   .core_clk(core_clk), .nrst(nrst), .scl_in(scl_in), .sda_oe(sda_oe),
   .wiper_code(wiper_code), .tap_sel(tap_sel), .if_ready(if_ready));

// *** sim/wpr_bus_master.sv ***
// two-wire bus master model driving the bench pins
`timescale 1ns/1ns
`include "wpr_defs.vh"
module wpr_bus_master (
   input  wire core_clk,
   input  wire sda_wire,
   output reg  scl_q,
   output reg  sda_low_q
);
   reg glitch_q = 1'b0; // adds a 32 ns clock spike to each bit's low phase
   initial begin
      scl_q = 1'b1;
      sda_low_q = 1'b0;
   end
   task w(input integer n);
      repeat (n) @(negedge core_clk);
   endtask
   // one 32-cycle phase with given data pull and clock level
   task ph(input sl, input sc);
      begin
         sda_low_q = sl;
         if (scl_q !== sc) scl_q = sc;   // the clock is never set twice in one step
         w(32);
      end
   endtask
   // one bit: data moves only well after the clock fell
   task bit_io(input b, output r);
      begin
         w(4);
         sda_low_q = !b;
         w(18);
         scl_q = glitch_q;
         w(8);
         scl_q = 1'b0;
         w(2);
         scl_q = 1'b1;
         w(16);
         r = sda_wire;
         w(16);
         scl_q = 1'b0;
      end
   endtask
   task byte_io(input [7:0] tx, input ack_in, output [7:0] rx, output ack);
      integer i;
      begin
         for (i = 7; i >= 0; i = i - 1) begin
            bit_io(tx[i], rx[i]);
         end
         bit_io(ack_in, ack);
      end
   endtask
   // start or repeated start, data falls while clock is high
   task start_c;
      begin
         ph(1'b0, 1'b0);
         ph(1'b0, 1'b1);
         ph(1'b1, 1'b1);
         ph(1'b1, 1'b0);
      end
   endtask
   task wr(input [6:0] id, input [7:0] a, input [7:0] d, output k1, output k2);
      reg [7:0] rx;
      reg       k3;
      begin
         start_c;
         byte_io({id, 1'b0}, 1'b1, rx, k1);
         byte_io(a, 1'b1, rx, k2);
         if (!k2) byte_io(d, 1'b1, rx, k3);
         ph(1'b1, 1'b0);
         ph(1'b1, 1'b1);
         ph(1'b0, 1'b1);
      end
   endtask
   // with mk set the master acks the first byte and takes a second one
   task rd(input [7:0] a, input mk, output [7:0] v);
      reg k;
      begin
         start_c;
         byte_io({`WPR_SLAVE_ID, 1'b0}, 1'b1, v, k);
         byte_io(a, 1'b1, v, k);
         start_c;
         byte_io({`WPR_SLAVE_ID, 1'b1}, 1'b1, v, k);
         byte_io(8'hff, !mk, v, k);
         if (mk) byte_io(8'hff, 1'b1, v, k);
         ph(1'b1, 1'b0);
         ph(1'b1, 1'b1);
         ph(1'b0, 1'b1);
      end
   endtask
endmodule

// *** sim/wpr_wiper_position_register_bench.sv ***
// self-checking bench for the wiper position register
`timescale 1ns/1ns
`include "wpr_defs.vh"
module wpr_wiper_position_register_bench;
   // rows of address, data, expected address nack, expected code
   localparam [119:0] ROWS = {24'h053390, 24'h012210, 24'h009010, 24'h007f7f, 24'h000000};
   reg            core_clk, nrst;           // clock and power-on reset
   wire           scl, sda_low, sda_wire;   // bus pins
   wire           sda_out, sda_oe, if_ready; // device outputs
   wire [6:0]     wiper_code;               // wiper position register
   wire [127:0]   tap_sel;                  // tap switches
   reg  [7:0]     a, d, v;                  // row fields and read value
   reg            ka, k1, k2;               // expected and seen acks
   reg  [6:0]     wc;                       // expected code
   integer        i, failures, samples_checked;
   // pull-up: either party may pull the data line low
   assign sda_wire = !(sda_low || (sda_oe && !sda_out));
   wpr_wiper_position_register #(.PWRUP_CYC(200)) dut (
      .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
      .sda_oe(sda_oe), .wiper_code(wiper_code), .tap_sel(tap_sel), .if_ready(if_ready));
   wpr_bus_master m (.core_clk(core_clk), .sda_wire(sda_wire), .scl_q(scl), .sda_low_q(sda_low));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task chk(input string what, input [127:0] exp, input [127:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
         end
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d failures %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // cut a hang short
   initial begin
      #200000;
      failures = failures + 1;
      tally_and_finish;
   end
   initial begin
      failures = 0;
      samples_checked = 0;
      // reset falls on a clock edge of its own so the design sees it
      nrst = 1'b1;
      @(negedge core_clk);
      nrst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("reset code", 7'h40, wiper_code);
      nrst = 1'b1;
      // a write during power-up recall is ignored
      m.wr(`WPR_SLAVE_ID, 8'h00, 8'h11, k1, k2);
      chk("early ack", 1'b1, k1);
      chk("early code", 7'h40, wiper_code);
      for (i = 0; i < 5; i = i + 1) begin
         {a, d, ka, wc} = ROWS[i*24 +: 24];
         m.wr(`WPR_SLAVE_ID, a, d, k1, k2);
         chk("id ack", 1'b0, k1);
         chk("addr ack", ka, k2);
         repeat (130) @(negedge core_clk);
         chk("code", wc, wiper_code);
         chk("taps", 128'h1 << wc, tap_sel);
         if (!ka) begin
            m.rd(a, 1'b0, v);
            chk("read", {1'b0, d[6:0]}, v);
         end
      end
      // a clock spike shorter than the filter adds no bit
      m.glitch_q = 1'b1;
      m.wr(`WPR_SLAVE_ID, 8'h00, 8'h2b, k1, k2);
      m.glitch_q = 1'b0;
      repeat (130) @(negedge core_clk);
      chk("spiked code", 7'h2b, wiper_code);
      // a foreign slave address is refused
      m.wr(`WPR_SLAVE_ID ^ 7'h01, 8'h00, 8'h05, k1, k2);
      chk("foreign ack", 1'b1, k1);
      chk("foreign code", 7'h2b, wiper_code);
      // a second power-on presets again
      nrst = 1'b0;
      @(negedge core_clk);
      chk("preset code", 7'h40, wiper_code);
      nrst = 1'b1;
      repeat (210) @(negedge core_clk);
      chk("ready", 1'b1, if_ready);
      // master ack makes the device send the register a second time
      m.rd(8'h01, 1'b1, v);
      chk("initial value", 8'h40, v);
      tally_and_finish;
   end
endmodule
